/* bench/ivc_core_model.sv */
/*
 * Processor core model: accepts whichever maskable request is offered.
 * Assumes the block's request outputs are settled by the falling edge.
 */
`timescale 1ns/100ps
module ivc_core_model
(
    input wire logic clk,
    input wire logic en,
    input wire logic irq_req,
    input wire logic [4:0] irq_num,
    output logic ack_stb,
    output logic [4:0] ack_num
);
    initial
    begin
        ack_stb = 1'b0;
        ack_num = 5'h00;
    end
    // One-cycle accept; a gap follows so a dropped request is not acked twice
    always @(negedge clk)
    begin
        ack_stb <= en && irq_req === 1'b1 && !ack_stb;
        ack_num <= irq_num;
    end
endmodule

/* bench/ivc_top_tb.sv */
/*
 * Self-checking bench for ivc_top: vectors, levels, steering, accept.
 * Assumes inputs are driven on falling edges, outputs read there too.
 */
`timescale 1ns/100ps
module ivc_top_tb_top
    import ivc_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, gie = 1'b0, wr = 1'b0, s0 = 1'b0, s1 = 1'b0;
    logic vreq = 1'b0, vfx = 1'b0, core_en = 1'b0;
    logic [2:0] processor_priority_level = 3'h0, i2c = 3'h0, irq_lvl;
    logic [4:0] idx = 5'h00, ridx = 5'h00, ack_num, irq_num;
    logic [7:0] wd = 8'h00, sd = 8'h00, breakpoint_instr = 8'h00, rdata, sel0, sel1;
    logic [5:0] ev = 6'h00, vnum = 6'h00, pins = 6'h3F;
    logic [19:0] vbase = 20'h10000, vaddr, idc_addr;
    ivc_fixed_t vkind = IVC_FX_UND, ikind = IVC_FX_UND;
    logic ack, irq, vvalid, vmsk, idc_en;
    int num_errors = 0, n_compared = 0;

    always #25 clk = ~clk;

    // Event lines share one vector so a single pulse hits many sources; I2C NACK, ACK and start on 5..3, stop on 2..0
    ivc_top dut_u (.CLK_SYS(clk), .RESET(rst), .GIE(gie), .PROCESSOR_PRIORITY_LEVEL(processor_priority_level), .VBASE(vbase),
        .CTL_WR(wr), .CTL_IDX(idx), .CTL_WDATA(wd), .CTL_RD_IDX(ridx), .CTL_RDATA(rdata),
        .SEL0_WR(s0), .SEL1_WR(s1), .SEL_WDATA(sd), .SEL0_RDATA(sel0), .SEL1_RDATA(sel1),
        .CAN_EV(ev[3:0]), .TMRA_EV(ev[4:0]), .TMRB_EV(ev), .DMA_EV(ev[1:0]),
        .ADC_EV(ev[0]), .KEY_EV(ev[1]), .SER3_EV(ev[2]), .I2C_MODE(i2c),
        .UART_TX_DONE(ev[2:0]), .UART_RX_DONE(ev[2:0]), .UART_NACK(ev[5:3]),
        .UART_ACK(ev[5:3]), .UART_COLL(ev[2:0]), .UART_START(ev[5:3]),
        .UART_STOP(ev[2:0]), .EXT_PIN(pins), .IRQ_REQ(irq), .IRQ_NUM(irq_num),
        .IRQ_LEVEL(irq_lvl), .ACK_STB(ack), .ACK_NUM(ack_num), .VEC_REQ(vreq),
        .VEC_FIXED(vfx), .VEC_KIND(vkind), .VEC_NUM(vnum), .BRK_HI_BYTE(breakpoint_instr),
        .VEC_VALID(vvalid), .VEC_ADDR(vaddr), .VEC_MASKABLE(vmsk), .IDC_KIND(ikind),
        .IDC_ADDR(idc_addr), .IDC_EN(idc_en));

    ivc_core_model core_u (.clk(clk), .en(core_en), .irq_req(irq), .irq_num(irq_num),
        .ack_stb(ack), .ack_num(ack_num));

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
        n_compared++;
        if (g !== e)
        begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Control write held for one cycle, then one idle cycle with the strobe low
    task automatic ctl(input logic [4:0] i, input logic [7:0] d);
        wr = 1'b1;
        idx = i;
        wd = d;
        cyc(1);
        wr = 1'b0;
        cyc(1);
    endtask

    task automatic rd(input logic [4:0] i, input logic [7:0] e);
        ridx = i;
        cyc(2);
        chk("ctl_rdata", {12'h0, e}, {12'h0, rdata});
    endtask

    // Vector request; latency counted in cycles until VEC_VALID
    task automatic vec(input logic fx, input ivc_fixed_t k, input logic [5:0] n,
        input logic [19:0] e, input int lat, input logic m);
        int c = 0;
        vreq = 1'b1;
        vfx = fx;
        vkind = k;
        vnum = n;
        cyc(1);
        vreq = 1'b0;
        while (vvalid !== 1'b1 && c < 4)
        begin
            cyc(1);
            c++;
        end
        chk("vec_latency", 20'(lat), 20'(c + 1));
        chk("vec_addr", e, vaddr);
        chk("vec_maskable", {19'h0, m}, {19'h0, vmsk});
        cyc(1);
    endtask

    task automatic pulse(input logic [5:0] e);
        ev = e;
        cyc(1);
        ev = 6'h00;
        cyc(4);
    endtask

    task automatic t_reset();
        rd(5'd11, 8'h00);
        rd(5'd4, 8'h00);
        chk("sel0", 20'h0, {12'h0, sel0});
        chk("sel1", 20'h0, {12'h0, sel1});
    endtask

    // Every fixed kind, with the ID check address of its high byte
    task automatic t_fixed();
        for (int k = 0; k < 9; k++)
        begin
            ikind = ivc_fixed_t'(k);
            vec(1'b1, ivc_fixed_t'(k), 6'h00, 20'hFFFDC + 20'(4 * k), 1, 1'b0);
            chk("idc_addr", 20'hFFFDF + 20'(4 * k), idc_addr);
            chk("idc_en", 20'h1, {19'h0, idc_en});
        end
    endtask

    task automatic t_reloc();
        vec(1'b0, IVC_FX_UND, 6'h00, 20'h10000, 1, 1'b0);
        vec(1'b0, IVC_FX_UND, 6'h05, 20'h10014, 1, 1'b1);
        vec(1'b0, IVC_FX_UND, 6'h1F, 20'h1007C, 1, 1'b1);
        vec(1'b0, IVC_FX_UND, 6'h20, 20'h10080, 1, 1'b0);
        vec(1'b0, IVC_FX_UND, 6'h3F, 20'h100FC, 1, 1'b0);
        vbase = 20'h10001;
        vec(1'b0, IVC_FX_UND, 6'h01, 20'h10005, 2, 1'b1);
        breakpoint_instr = 8'hFF;
        vec(1'b1, IVC_FX_BRK, 6'h00, 20'h10001, 2, 1'b0);
        breakpoint_instr = 8'hFE;
        vec(1'b1, IVC_FX_BRK, 6'h00, 20'hFFFE4, 1, 1'b0);
    endtask

    // Gating by enable, core level and own level; request bit writes
    task automatic t_level();
        ctl(5'd11, 8'h05);
        gie = 1'b1;
        processor_priority_level = 3'h4;
        pulse(6'h01);
        chk("irq_req", 20'h1, {19'h0, irq});
        chk("irq_num", 20'd11, {15'h0, irq_num});
        chk("irq_level", 20'h5, {17'h0, irq_lvl});
        processor_priority_level = 3'h5;
        cyc(3);
        chk("irq_req ipl", 20'h0, {19'h0, irq});
        processor_priority_level = 3'h4;
        gie = 1'b0;
        cyc(3);
        chk("irq_req gie", 20'h0, {19'h0, irq});
        rd(5'd11, 8'h0D);
        ctl(5'd11, 8'h05);
        rd(5'd11, 8'h05);
        ctl(5'd11, 8'h1D);
        rd(5'd11, 8'h15);
        ctl(5'd11, 8'h05);
    endtask

    // Entry 14 steered to key input; the converter event must not reach it
    task automatic t_select_accept();
        s0 = 1'b1;
        sd = 8'h02;
        cyc(1);
        s0 = 1'b0;
        ctl(5'd14, 8'h06);
        chk("sel0 key", 20'h02, {12'h0, sel0});
        gie = 1'b1;
        pulse(6'h01);
        chk("irq_num adc", 20'd11, {15'h0, irq_num});
        pulse(6'h02);
        chk("irq_num key", 20'd14, {15'h0, irq_num});
        chk("irq_level key", 20'h6, {17'h0, irq_lvl});
        core_en = 1'b1;
        cyc(12);
        core_en = 1'b0;
        chk("irq_req after", 20'h0, {19'h0, irq});
        rd(5'd14, 8'h06);
        rd(5'd11, 8'h05);
    endtask

    // Pins 0 and 5 fall; pin 5 reaches entry 8 only once its select bit is set
    task automatic t_pins();
        ctl(5'd29, 8'h07);
        ctl(5'd8, 8'h07);
        pins = 6'h1E;
        cyc(8);
        chk("irq_num pin0", 20'd29, {15'h0, irq_num});
        ctl(5'd29, 8'h00);
        cyc(2);
        chk("irq_req pin5 off", 20'h0, {19'h0, irq});
        s1 = 1'b1;
        sd = 8'hA0;
        cyc(1);
        s1 = 1'b0;
        pins = 6'h3F;
        cyc(8);
        chk("irq_num pin5 rise", 20'd8, {15'h0, irq_num});
        chk("sel1 both edge", 20'hA0, {12'h0, sel1});
        ctl(5'd8, 8'h00);
    endtask

    // Entry 7 on UART0 collision; I2C start and NACK raise entries 7 and 17
    task automatic t_serial();
        s0 = 1'b1;
        sd = 8'h42;
        cyc(1);
        s0 = 1'b0;
        ctl(5'd7, 8'h06);
        pulse(6'h08);
        chk("irq_req timer b3", 20'h0, {19'h0, irq});
        pulse(6'h01);
        chk("irq_num collision", 20'd7, {15'h0, irq_num});
        ctl(5'd7, 8'h06);
        ctl(5'd17, 8'h07);
        i2c = 3'h1;
        pulse(6'h08);
        chk("irq_num nack", 20'd17, {15'h0, irq_num});
        rd(5'd7, 8'h0E);
        // Clear write and event in one cycle: the event must win
        ctl(5'd11, 8'h05);
        wr = 1'b1;
        ev = 6'h01;
        cyc(1);
        wr = 1'b0;
        ev = 6'h00;
        rd(5'd11, 8'h0D);
    endtask

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        cyc(20);
        rst = 1'b0;
        cyc(1);
        t_reset();
        t_fixed();
        t_reloc();
        t_level();
        t_select_accept();
        t_pins();
        t_serial();
        conclude();
    end

    // Whole run is about 170 cycles (under 9 us); this span is far beyond it
    initial
    begin
        #200us;
        num_errors++;
        conclude();
    end
endmodule

/* include/ivc_pkg.sv */
/*
 * Shared constants for the interrupt vector and control block: fixed
 * vector bases, relocatable table geometry, control and select field
 * positions, and the source entry numbers.
 * Assumes a 20-bit byte address space with vectors of four bytes.
 */
package ivc_pkg;

    localparam int IVC_NSRC = 31;
    localparam int IVC_ADDR_W = 20;

    // Fixed vector bases, top of the address space
    localparam logic [19:0] IVC_FIX_UND = 20'hFFFDC;
    localparam logic [19:0] IVC_FIX_OVF = 20'hFFFE0;
    localparam logic [19:0] IVC_FIX_BRK = 20'hFFFE4;
    localparam logic [19:0] IVC_FIX_AMATCH = 20'hFFFE8;
    localparam logic [19:0] IVC_FIX_SSTEP = 20'hFFFEC;
    localparam logic [19:0] IVC_FIX_WDT = 20'hFFFF0;
    localparam logic [19:0] IVC_FIX_DBG = 20'hFFFF4;
    localparam logic [19:0] IVC_FIX_NMI = 20'hFFFF8;
    localparam logic [19:0] IVC_FIX_RST = 20'hFFFFC;
    localparam logic [19:0] IVC_FIX_TOP = 20'hFFFFF;

    // Vector geometry
    localparam logic [19:0] IVC_VEC_HI_OFS = 20'h00003;
    localparam logic [19:0] IVC_RELOC_SPAN = 20'h00100;
    localparam logic [5:0] IVC_SOFT_LAST_MASKABLE = 6'h1F;
    localparam logic [7:0] IVC_BRK_REDIRECT = 8'hFF;

    // Control register fields
    localparam int IVC_LVL_LSB = 0;
    localparam int IVC_REQ_BIT = 3;
    localparam int IVC_POL_BIT = 4;
    localparam logic [2:0] IVC_LVL_RST = 3'h0;
    localparam logic [7:0] IVC_SEL_RST = 8'h00;

    // Source-select bit positions
    localparam int IVC_SEL0_SER3 = 0;
    localparam int IVC_SEL0_ADCKEY = 1;
    localparam int IVC_SEL0_CAN = 2;
    localparam int IVC_SEL0_TB3 = 6;
    localparam int IVC_SEL0_TB4 = 7;
    localparam int IVC_SEL1_PIN4 = 6;
    localparam int IVC_SEL1_PIN5 = 7;

    // Entry numbers referenced by name
    localparam int IVC_ENT_DMA0 = 11;
    localparam int IVC_ENT_TMRA0 = 21;
    localparam int IVC_ENT_PIN0 = 29;
    // Control entry that owns each external pin 0..5
    localparam int IVC_PIN_ENTRY [0:5] = '{29, 30, 31, 4, 9, 8};

    typedef enum logic [3:0] {
        IVC_FX_UND, IVC_FX_OVF, IVC_FX_BRK, IVC_FX_AMATCH, IVC_FX_SSTEP,
        IVC_FX_WDT, IVC_FX_DBG, IVC_FX_NMI, IVC_FX_RST
    } ivc_fixed_t;

    // Base address of a fixed vector; watchdog and clock-stop share one
    function automatic logic [19:0] ivc_fixed_base(input ivc_fixed_t kind);
        logic [19:0] base;
        base = IVC_FIX_RST;
        unique case (kind)
            IVC_FX_UND: base = IVC_FIX_UND;
            IVC_FX_OVF: base = IVC_FIX_OVF;
            IVC_FX_BRK: base = IVC_FIX_BRK;
            IVC_FX_AMATCH: base = IVC_FIX_AMATCH;
            IVC_FX_SSTEP: base = IVC_FIX_SSTEP;
            IVC_FX_WDT: base = IVC_FIX_WDT;
            IVC_FX_DBG: base = IVC_FIX_DBG;
            IVC_FX_NMI: base = IVC_FIX_NMI;
            IVC_FX_RST: base = IVC_FIX_RST;
            default: base = IVC_FIX_RST;
        endcase
        return base;
    endfunction

endpackage

/* verilog/ivc_pin_edge.sv */
/*
 * External interrupt pin edge detector: three-stage synchroniser,
 * agreement filter, falling, rising or both-edge selection.
 * Assumes the pin idles high and is asynchronous to CLK_SYS.
 */
`timescale 1ns/100ps
module ivc_pin_edge
    import ivc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic pin_in,
    input wire logic rise_sel,
    input wire logic both_sel,
    output logic edge_ev
);

    logic sync1_reg;
    logic sync2_reg;
    logic sync3_reg;
    logic level_reg;
    logic rise;
    logic fall;

    // Synchroniser chain; the first stage feeds only the second
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
            sync3_reg <= 1'b1;
        end
        else
        begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // A change counts once stages two and three agree
    assign rise = (sync2_reg == sync3_reg) && sync2_reg && !level_reg;
    assign fall = (sync2_reg == sync3_reg) && !sync2_reg && level_reg;

    // Filtered level and one-cycle edge pulse
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            level_reg <= 1'b1;
            edge_ev <= 1'b0;
        end
        else
        begin
            if (rise || fall)
                level_reg <= sync2_reg;
            edge_ev <= both_sel ? (rise || fall) : (rise_sel ? rise : fall);
        end
    end

endmodule

/* verilog/ivc_top.sv */
/*
 * Interrupt vector and maskable interrupt control: per-source control
 * (request, level, polarity), source-select steering, serial mode
 * event selection, level gating against the processor priority, and
 * vector address generation for the core.
 * Assumes all event inputs except EXT_PIN are one-cycle pulses on
 * CLK_SYS; EXT_PIN is asynchronous and idles high.
 */
`timescale 1ns/100ps
// Operation
// - A vector is four bytes holding the routine start; accepted requests branch there.
// - Fixed vectors fill the top of memory from FFFDC to FFFFF.
// - Fixed bases: undefined, overflow, break, match, step, watchdog, debug, pin, reset.
// - Clock-stop detection and watchdog share one fixed vector.
// - Breakpoint uses relocatable entry zero when byte FFFE7 reads FF.
// - Flash versions feed fixed vector high bytes to the ID check.
// - Relocatable table is 256 bytes from the vector base, 64 entries.
// - Software number n sits at base plus four times n, 0 to 63.
// - An even vector base makes the sequence faster than an odd one.
// - Entries 1 to 31 serve the peripheral sources in fixed order.
// - Software numbers 0 and 32 to 63 ignore the global enable.
// - Select register 0 bits 7, 6, 1 steer the shared entries.
// - Entry 9 picks serial 3 or pin 4; serial 3 also needs bit 0.
// - In I2C mode NACK and ACK raise the transmit and receive entries.
// - Collision entries use collision in IE mode, start or stop in I2C.
// - Each source is gated by global enable, core level and own level.
// - Software may only write 0 to the request bit, clearing it.
// - Request sets on the event and clears when the core accepts it.
// - Accept only when enabled, requested, and level above core level.
// - Level 000 disables; 001 to 111 are levels 1 to 7.
module ivc_top
    import ivc_pkg::*;
#(
    parameter bit FLASH_VER = 1'b1
)
(
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic GIE,
    input wire logic [2:0] PROCESSOR_PRIORITY_LEVEL,
    input wire logic [19:0] VBASE,
    input wire logic CTL_WR,
    input wire logic [4:0] CTL_IDX,
    input wire logic [7:0] CTL_WDATA,
    input wire logic [4:0] CTL_RD_IDX,
    output logic [7:0] CTL_RDATA,
    input wire logic SEL0_WR,
    input wire logic SEL1_WR,
    input wire logic [7:0] SEL_WDATA,
    output logic [7:0] SEL0_RDATA,
    output logic [7:0] SEL1_RDATA,
    input wire logic [3:0] CAN_EV,
    input wire logic [4:0] TMRA_EV,
    input wire logic [5:0] TMRB_EV,
    input wire logic [1:0] DMA_EV,
    input wire logic ADC_EV,
    input wire logic KEY_EV,
    input wire logic SER3_EV,
    input wire logic [2:0] I2C_MODE,
    input wire logic [2:0] UART_TX_DONE,
    input wire logic [2:0] UART_RX_DONE,
    input wire logic [2:0] UART_NACK,
    input wire logic [2:0] UART_ACK,
    input wire logic [2:0] UART_COLL,
    input wire logic [2:0] UART_START,
    input wire logic [2:0] UART_STOP,
    input wire logic [5:0] EXT_PIN,
    output logic IRQ_REQ,
    output logic [4:0] IRQ_NUM,
    output logic [2:0] IRQ_LEVEL,
    input wire logic ACK_STB,
    input wire logic [4:0] ACK_NUM,
    input wire logic VEC_REQ,
    input wire logic VEC_FIXED,
    input ivc_fixed_t VEC_KIND,
    input wire logic [5:0] VEC_NUM,
    input wire logic [7:0] BRK_HI_BYTE,
    output logic VEC_VALID,
    output logic [19:0] VEC_ADDR,
    output logic VEC_MASKABLE,
    input ivc_fixed_t IDC_KIND,
    output logic [19:0] IDC_ADDR,
    output logic IDC_EN
);

    logic [2:0] lvl_reg [1:IVC_NSRC];
    logic [IVC_NSRC:1] pol_reg;
    logic [IVC_NSRC:1] req_reg;
    logic [7:0] sel0_reg;
    logic [7:0] sel1_reg;
    logic [IVC_NSRC:1] ev;
    logic [5:0] pin_ev;
    logic [2:0] tx_ev;
    logic [2:0] rx_ev;
    logic [2:0] coll_ev;
    logic [2:0] best_lvl;
    logic [4:0] best_num;
    logic best_hit;

    // Source-select registers; software owns every bit
    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
        begin
            sel0_reg <= IVC_SEL_RST;
            sel1_reg <= IVC_SEL_RST;
        end
        else
        begin
            if (SEL0_WR)
                sel0_reg <= SEL_WDATA;
            if (SEL1_WR)
                sel1_reg <= SEL_WDATA;
        end
    end

    assign SEL0_RDATA = sel0_reg;
    assign SEL1_RDATA = sel1_reg;

    // External pins: synchronised, edge picked by polarity and both-edge
    genvar g;
    generate
        for (g = 0; g < 6; g++)
        begin : gen_pin
            ivc_pin_edge u_edge (
                .clk(CLK_SYS),
                .rst(RESET),
                .pin_in(EXT_PIN[g]),
                .rise_sel(pol_reg[IVC_PIN_ENTRY[g]]),
                .both_sel(sel1_reg[g]),
                .edge_ev(pin_ev[g])
            );
        end
    endgenerate

    // Serial event choice follows the port mode
    always_comb
    begin
        for (int u = 0; u < 3; u++)
        begin
            tx_ev[u] = I2C_MODE[u] ? UART_NACK[u] : UART_TX_DONE[u];
            rx_ev[u] = I2C_MODE[u] ? UART_ACK[u] : UART_RX_DONE[u];
            coll_ev[u] = I2C_MODE[u] ? (UART_START[u] | UART_STOP[u]) : UART_COLL[u];
        end
    end

    // Entry map; shared entries are steered by the select registers
    always_comb
    begin
        ev = '0;
        ev[1] = CAN_EV[0] & !sel0_reg[IVC_SEL0_CAN];
        ev[2] = CAN_EV[1];
        ev[3] = CAN_EV[2];
        ev[4] = pin_ev[3];
        ev[5] = TMRB_EV[5];
        ev[6] = sel0_reg[IVC_SEL0_TB4] ? coll_ev[1] : TMRB_EV[4];
        ev[7] = sel0_reg[IVC_SEL0_TB3] ? coll_ev[0] : TMRB_EV[3];
        ev[8] = sel1_reg[IVC_SEL1_PIN5] & pin_ev[5];
        // Serial 3 reaches the entry only with its route bit set as well
        ev[9] = sel1_reg[IVC_SEL1_PIN4] ? pin_ev[4]
            : (sel0_reg[IVC_SEL0_SER3] & SER3_EV);
        ev[10] = coll_ev[2];
        ev[IVC_ENT_DMA0] = DMA_EV[0];
        ev[IVC_ENT_DMA0 + 1] = DMA_EV[1];
        ev[13] = CAN_EV[3] & !sel0_reg[IVC_SEL0_CAN];
        ev[14] = sel0_reg[IVC_SEL0_ADCKEY] ? KEY_EV : ADC_EV;
        ev[15] = tx_ev[2];
        ev[16] = rx_ev[2];
        ev[17] = tx_ev[0];
        ev[18] = rx_ev[0];
        ev[19] = tx_ev[1];
        ev[20] = rx_ev[1];
        ev[IVC_ENT_TMRA0 +: 5] = TMRA_EV;
        ev[IVC_ENT_TMRA0 + 5 +: 3] = TMRB_EV[2:0];
        ev[IVC_ENT_PIN0 +: 3] = pin_ev[2:0];
    end

    // Per-source control: level and polarity by write, request by event
    generate
        for (g = 1; g <= IVC_NSRC; g++)
        begin : gen_ctl
            logic hit;
            assign hit = CTL_WR && CTL_IDX == 5'(g);
            always_ff @(posedge CLK_SYS)
            begin
                if (RESET)
                begin
                    lvl_reg[g] <= IVC_LVL_RST;
                    pol_reg[g] <= 1'b0;
                end
                else if (hit)
                begin
                    lvl_reg[g] <= CTL_WDATA[IVC_LVL_LSB +: 3];
                    pol_reg[g] <= CTL_WDATA[IVC_POL_BIT];
                end
            end
            // A new event beats a same-cycle clear, so none is lost
            always_ff @(posedge CLK_SYS)
            begin
                if (RESET)
                    req_reg[g] <= 1'b0;
                else if (ev[g])
                    req_reg[g] <= 1'b1;
                else if (ACK_STB && ACK_NUM == 5'(g))
                    req_reg[g] <= 1'b0;
                else if (hit && !CTL_WDATA[IVC_REQ_BIT])
                    req_reg[g] <= 1'b0;
            end
        end
    endgenerate

    // Registered read-back; index 0 is unused and reads zero
    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
            CTL_RDATA <= 8'h00;
        else if (CTL_RD_IDX == 5'h00)
            CTL_RDATA <= 8'h00;
        else
            CTL_RDATA <= {3'h0, pol_reg[CTL_RD_IDX], req_reg[CTL_RD_IDX],
                lvl_reg[CTL_RD_IDX]};
    end

    // Highest level above the core level wins; ties go to the lower entry
    always_comb
    begin
        best_lvl = 3'h0;
        best_num = 5'h00;
        best_hit = 1'b0;
        for (int i = IVC_NSRC; i >= 1; i--)
        begin
            if (req_reg[i] && lvl_reg[i] > PROCESSOR_PRIORITY_LEVEL && lvl_reg[i] >= best_lvl)
            begin
                best_lvl = lvl_reg[i];
                best_num = 5'(i);
                best_hit = 1'b1;
            end
        end
    end

    // Offer to the core, gated by the global enable
    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
        begin
            IRQ_REQ <= 1'b0;
            IRQ_NUM <= 5'h00;
            IRQ_LEVEL <= 3'h0;
        end
        else
        begin
            IRQ_REQ <= GIE && best_hit && !ACK_STB;
            IRQ_NUM <= best_num;
            IRQ_LEVEL <= best_lvl;
        end
    end

    // Vector address generation for fixed and relocatable tables
    ivc_vec_addr #(
        .FLASH_VER(FLASH_VER)
    ) u_vec (
        .clk(CLK_SYS),
        .rst(RESET),
        .vec_req(VEC_REQ),
        .vec_fixed(VEC_FIXED),
        .vec_kind(VEC_KIND),
        .vec_num(VEC_NUM),
        .vbase(VBASE),
        .brk_hi_byte(BRK_HI_BYTE),
        .idc_kind(IDC_KIND),
        .vec_valid(VEC_VALID),
        .vec_addr(VEC_ADDR),
        .vec_maskable(VEC_MASKABLE),
        .idc_addr(IDC_ADDR),
        .idc_en(IDC_EN)
    );

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RESET);

    AST_REQ_SET: assert property (DMA_EV[0] |=> req_reg[IVC_ENT_DMA0])
        else $error("request bit not set by event");
    AST_ACK_CLEAR: assert property (ACK_STB && ACK_NUM == 5'h0B && !DMA_EV[0]
        |=> !req_reg[IVC_ENT_DMA0])
        else $error("request bit not cleared on accept");
    AST_WRITE_ONE_IGNORED: assert property (CTL_WR && CTL_IDX == 5'h0B
        && CTL_WDATA[IVC_REQ_BIT] && !req_reg[IVC_ENT_DMA0] && !DMA_EV[0]
        |=> !req_reg[IVC_ENT_DMA0])
        else $error("writing one set the request bit");
    AST_SET_WINS: assert property (CTL_WR && CTL_IDX == 5'h0B
        && !CTL_WDATA[IVC_REQ_BIT] && DMA_EV[0] |=> req_reg[IVC_ENT_DMA0])
        else $error("clear beat a same-cycle event");
    AST_GIE_MASK: assert property (!GIE |=> !IRQ_REQ)
        else $error("request offered with global enable low");
    AST_ABOVE_IPL: assert property (IRQ_REQ |-> IRQ_LEVEL > $past(PROCESSOR_PRIORITY_LEVEL))
        else $error("offered level not above core level");
    AST_LVL_ZERO: assert property (IRQ_REQ |-> IRQ_LEVEL != 3'h0 && IRQ_NUM != 5'h00)
        else $error("disabled level offered");
    AST_SEL_TB3: assert property (sel0_reg[IVC_SEL0_TB3] && UART_COLL[0]
        && !I2C_MODE[0] |-> ev[7])
        else $error("collision not steered to shared entry");
    AST_I2C_NACK: assert property (I2C_MODE[0] && UART_NACK[0] |-> ev[17])
        else $error("NACK did not raise transmit entry");
    AST_ENTRY9: assert property (!sel1_reg[IVC_SEL1_PIN4] && !sel0_reg[IVC_SEL0_SER3]
        |-> !ev[9])
        else $error("serial 3 raised entry without route bit");
    AST_VEC_EVEN: assert property (VEC_REQ && !VEC_FIXED && !VBASE[0]
        |=> VEC_VALID && VEC_ADDR == $past(VBASE) + {12'h000, $past(VEC_NUM), 2'b00})
        else $error("relocatable address wrong");
    AST_VEC_ODD: assert property (VEC_REQ && !VEC_FIXED && VBASE[0]
        |=> !VEC_VALID ##1 VEC_VALID)
        else $error("odd base not one cycle slower");
    AST_BRK_REDIRECT: assert property (VEC_REQ && VEC_FIXED && VEC_KIND == IVC_FX_BRK
        && BRK_HI_BYTE == IVC_BRK_REDIRECT && !VBASE[0] |=> VEC_ADDR == $past(VBASE))
        else $error("breakpoint not redirected");
    AST_FIXED_WDT: assert property (VEC_REQ && VEC_FIXED && VEC_KIND == IVC_FX_WDT
        |=> VEC_VALID && VEC_ADDR == IVC_FIX_WDT)
        else $error("shared fixed vector wrong");
    AST_UNMASKABLE: assert property (VEC_REQ && !VEC_FIXED && VEC_NUM[5]
        |=> ##[0:1] !VEC_MASKABLE)
        else $error("high software number marked maskable");

    COV_ACCEPT: cover property (IRQ_REQ ##1 ACK_STB);
    COV_ODD_VEC: cover property (VEC_REQ && !VEC_FIXED && VBASE[0]);
    COV_BRK_REDIRECT: cover property (VEC_REQ && VEC_FIXED && VEC_KIND == IVC_FX_BRK
        && BRK_HI_BYTE == IVC_BRK_REDIRECT);
    COV_PIN_EDGE: cover property (|pin_ev);

endmodule

/* verilog/ivc_vec_addr.sv */
/*
 * Vector address unit: fixed table lookup, relocatable entry offset
 * from the vector base, breakpoint redirection, and the address of
 * the high byte of each fixed vector for the ID code check.
 * Assumes one vector request at a time, none while one is pending.
 */
`timescale 1ns/100ps
module ivc_vec_addr
    import ivc_pkg::*;
#(
    parameter bit FLASH_VER = 1'b1
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic vec_req,
    input wire logic vec_fixed,
    input ivc_fixed_t vec_kind,
    input wire logic [5:0] vec_num,
    input wire logic [19:0] vbase,
    input wire logic [7:0] brk_hi_byte,
    input ivc_fixed_t idc_kind,
    output logic vec_valid,
    output logic [19:0] vec_addr,
    output logic vec_maskable,
    output logic [19:0] idc_addr,
    output logic idc_en
);

    logic use_reloc;
    logic [5:0] entry;
    logic [19:0] addr_next;
    logic hold_reg;

    // Breakpoint with an erased high byte goes to relocatable entry 0
    always_comb
    begin
        use_reloc = !vec_fixed;
        entry = vec_num;
        if (vec_fixed && vec_kind == IVC_FX_BRK && brk_hi_byte == IVC_BRK_REDIRECT)
        begin
            use_reloc = 1'b1;
            entry = 6'h00;
        end
        // Four bytes per entry, 64 entries across a 256-byte region
        if (use_reloc)
            addr_next = vbase + {12'h000, entry, 2'b00};
        else
            addr_next = ivc_fixed_base(vec_kind);
    end

    // Odd base costs one more cycle before the address is offered
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            vec_valid <= 1'b0;
            hold_reg <= 1'b0;
            vec_addr <= 20'h00000;
            vec_maskable <= 1'b0;
        end
        else
        begin
            hold_reg <= vec_req && use_reloc && vbase[0];
            vec_valid <= (vec_req && !(use_reloc && vbase[0])) || hold_reg;
            if (vec_req)
            begin
                vec_addr <= addr_next;
                // Only software numbers 1..31 obey the global enable
                vec_maskable <= !vec_fixed && vec_num != 6'h00
                    && vec_num <= IVC_SOFT_LAST_MASKABLE;
            end
        end
    end

    // High byte of a fixed vector, read by the flash protection check
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            idc_addr <= 20'h00000;
            idc_en <= 1'b0;
        end
        else
        begin
            idc_addr <= ivc_fixed_base(idc_kind) + IVC_VEC_HI_OFS;
            idc_en <= FLASH_VER;
        end
    end

endmodule
